/* hdl/rssr_fifo.sv */
`timescale 1ns/1ns
module rssr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic  clk_in,   // Block clock.
	input  wire logic  reset_in, // Synchronous reset, active high.
	rssr_stream_if.snk wr,       // Filling side.
	rssr_stream_if.src rd        // Draining side.
);
	import rssr_pkg::*;

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} rssr_fifo_st_t;

	rssr_fifo_st_t st_ff;
	rssr_fifo_st_t nxt_st;
	logic          full;
	logic          empty;

	// Pointers carry one extra bit so full and empty are told apart.
	assign empty    = (st_ff.wp == st_ff.rp);
	assign full     = (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]) &&
	                  (st_ff.wp[AW] != st_ff.rp[AW]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = st_ff.mem[st_ff.rp[AW-1:0]];

	always_comb begin
		nxt_st = st_ff;
		if (wr.valid && !full) begin
			nxt_st.mem[st_ff.wp[AW-1:0]] = wr.data;
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		if (rd.ready && !empty) begin
			nxt_st.rp = st_ff.rp + 1'b1;
		end
		if (reset_in) begin
			nxt_st = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		st_ff <= nxt_st;
	end
endmodule

/* hdl/rssr_params.svh */
`ifndef RSSR_PARAMS_SVH
`define RSSR_PARAMS_SVH

// Serial timing: clock rate and baud rate, and the bit time in cycles.
`define RSSR_CLK_HZ       25000000
`define RSSR_BAUD         1000000
`define RSSR_BIT_CYC      ((`RSSR_CLK_HZ + (`RSSR_BAUD / 2)) / `RSSR_BAUD)
`define RSSR_HALF_CYC     (`RSSR_BIT_CYC / 2)
`define RSSR_CNT_W        12
`define RSSR_DATA_BITS    4'h8
`define RSSR_FRAME_BITS   4'ha

// Characters on the link.
`define RSSR_CHAR_REQ     8'h52
`define RSSR_CHAR_SPACE   8'h20
`define RSSR_CHAR_ZERO    4'h3

// Values per game.
`define RSSR_MAX_VALS     75
`define RSSR_IDX_W        7
`define RSSR_VAL_W        8
`define RSSR_N_POKER      7'h0a
`define RSSR_N_BJACK      7'h12
`define RSSR_N_KENO       7'h14
`define RSSR_N_BINGO      7'h4b
`define RSSR_N_CRAPS      7'h02
`define RSSR_N_ROUL       7'h01

// Decimal field widths and their thresholds.
`define RSSR_DEC_100      8'h64
`define RSSR_DEC_10       8'h0a
`define RSSR_DIG_1        2'h1
`define RSSR_DIG_2        2'h2
`define RSSR_DIG_3        2'h3

// Character buffer.
`define RSSR_FIFO_W       8
`define RSSR_FIFO_D       16

`endif

/* hdl/rssr_pkg.sv */
package rssr_pkg;
	`include "rssr_params.svh"

	typedef enum logic [2:0] {
		GAME_POKER,
		GAME_BJACK,
		GAME_KENO,
		GAME_SLOT,
		GAME_BINGO,
		GAME_CRAPS,
		GAME_ROUL
	} rssr_game_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EMIT,
		ST_DRAIN
	} rssr_main_t;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rssr_rx_t;

	typedef enum logic {
		TX_IDLE,
		TX_SHIFT
	} rssr_tx_t;
endpackage

/* hdl/rssr_stream_if.sv */
`timescale 1ns/1ns
interface rssr_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

/* hdl/rssr_top.sv */
`timescale 1ns/1ns
module rssr_top (
	input  wire logic               clk_in,          // Block clock.
	input  wire logic               reset_in,        // Sync reset, high.
	input  wire logic               rx_in,           // Serial receive pin.
	input  rssr_pkg::rssr_game_t    game_in,         // Game type.
	input  wire logic [3:0]         reel_count_in,   // Reels of a slot.
	input  wire logic [7:0]         max_value_in,    // Largest value.
	input  wire logic [7:0]         rng_value_in,    // Generator value.
	input  wire logic               rng_ack_in,      // Value is valid.
	output logic                    tx_out,          // Serial send pin.
	output logic                    rng_req_out,     // Value wanted.
	output logic                    test_active_out, // Exchange running.
	output logic                    frame_err_out    // Bad stop bit.
);
	import rssr_pkg::*;

	typedef struct packed {
		logic                                       rx_s1;
		logic                                       rx_s2;
		rssr_rx_t                                   rx_st;
		logic [`RSSR_CNT_W-1:0]                     rx_cnt;
		logic [3:0]                                 rx_bit;
		logic [7:0]                                 rx_sh;
		logic                                       frame_err;
		rssr_main_t                                 st;
		logic [`RSSR_IDX_W-1:0]                     total;
		logic [1:0]                                 ndig;
		logic [`RSSR_IDX_W-1:0]                     cnt;
		logic [`RSSR_IDX_W-1:0]                     idx;
		logic [1:0]                                 dpos;
		logic                                       sp;
		logic [`RSSR_MAX_VALS-1:0][`RSSR_VAL_W-1:0] vals;
		logic                                       rng_req;
		logic                                       active;
		logic [7:0]                                 push_data;
		logic                                       push_vld;
		rssr_tx_t                                   tx_st;
		logic [`RSSR_CNT_W-1:0]                     tx_cnt;
		logic [3:0]                                 tx_bit;
		logic [9:0]                                 tx_sh;
		logic                                       tx;
	} rssr_st_t;

	rssr_st_t st_ff;
	rssr_st_t nxt_st;
	logic     push_rdy;
	logic     pop_vld;
	logic     pop_rdy;
	logic [7:0] pop_data;

	rssr_stream_if #(.WIDTH(`RSSR_FIFO_W)) push_if ();
	rssr_stream_if #(.WIDTH(`RSSR_FIFO_W)) pop_if ();

	assign push_if.data  = st_ff.push_data;
	assign push_if.valid = st_ff.push_vld;
	assign push_rdy      = push_if.ready;
	assign pop_vld       = pop_if.valid;
	assign pop_data      = pop_if.data;
	assign pop_if.ready  = pop_rdy;

	// The buffer lets the formatter run ahead of the slow serial line.
	rssr_fifo #(
		.WIDTH(`RSSR_FIFO_W),
		.DEPTH(`RSSR_FIFO_D)
	) u_fifo (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.wr       (push_if.snk),
		.rd       (pop_if.src)
	);

	function automatic logic [`RSSR_IDX_W-1:0] value_count(
		input rssr_game_t g,
		input logic [3:0] reels
	);
		logic [`RSSR_IDX_W-1:0] n;
		n = `RSSR_N_ROUL;
		case (g)
			GAME_POKER: n = `RSSR_N_POKER;
			GAME_BJACK: n = `RSSR_N_BJACK;
			GAME_KENO:  n = `RSSR_N_KENO;
			GAME_SLOT: begin
				// A slot with no reels set still reports one stop.
				n = (reels == 4'h0) ? `RSSR_N_ROUL : {3'h0, reels};
			end
			GAME_BINGO: n = `RSSR_N_BINGO;
			GAME_CRAPS: n = `RSSR_N_CRAPS;
			GAME_ROUL:  n = `RSSR_N_ROUL;
			default:    n = `RSSR_N_ROUL;
		endcase
		return n;
	endfunction

	function automatic logic [1:0] digit_count(
		input rssr_game_t g,
		input logic [7:0] maxv
	);
		logic [1:0] d;
		if (g == GAME_CRAPS) begin
			d = `RSSR_DIG_1;
		end else if (maxv >= `RSSR_DEC_100) begin
			d = `RSSR_DIG_3;
		end else if (maxv >= `RSSR_DEC_10) begin
			d = `RSSR_DIG_2;
		end else begin
			d = `RSSR_DIG_1;
		end
		return d;
	endfunction

	// Digit position 0 is the ones, 1 the tens, 2 the hundreds.
	function automatic logic [7:0] dec_char(
		input logic [7:0] v,
		input logic [1:0] pos
	);
		logic [7:0] q;
		logic [3:0] dg;
		q = v;
		if (pos == 2'h2) begin
			q = v / `RSSR_DEC_100;
		end else if (pos == 2'h1) begin
			q = (v % `RSSR_DEC_100) / `RSSR_DEC_10;
		end
		dg = 4'(q % `RSSR_DEC_10);
		return {`RSSR_CHAR_ZERO, dg};
	endfunction

	always_comb begin
		nxt_st  = st_ff;
		pop_rdy = 1'b0;

		// Receiver, 8N1; the first stage only feeds the second.
		nxt_st.rx_s1 = rx_in;
		nxt_st.rx_s2 = st_ff.rx_s1;
		if (st_ff.rx_cnt != '0) begin
			nxt_st.rx_cnt = st_ff.rx_cnt - 1'b1;
		end
		case (st_ff.rx_st)
			RX_IDLE: begin
				if (!st_ff.rx_s2) begin
					nxt_st.rx_st  = RX_START;
					nxt_st.rx_cnt = `RSSR_CNT_W'(`RSSR_HALF_CYC - 1);
				end
			end
			RX_START: begin
				if (st_ff.rx_cnt == '0) begin
					// A glitch shorter than half a bit is no start bit.
					nxt_st.rx_st  = st_ff.rx_s2 ? RX_IDLE : RX_DATA;
					nxt_st.rx_cnt = `RSSR_CNT_W'(`RSSR_BIT_CYC - 1);
					nxt_st.rx_bit = '0;
				end
			end
			RX_DATA: begin
				if (st_ff.rx_cnt == '0) begin
					nxt_st.rx_sh  = {st_ff.rx_s2, st_ff.rx_sh[7:1]};
					nxt_st.rx_bit = st_ff.rx_bit + 1'b1;
					nxt_st.rx_cnt = `RSSR_CNT_W'(`RSSR_BIT_CYC - 1);
					if (st_ff.rx_bit == `RSSR_DATA_BITS - 4'h1) begin
						nxt_st.rx_st = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (st_ff.rx_cnt == '0) begin
					nxt_st.rx_st     = RX_IDLE;
					nxt_st.frame_err = !st_ff.rx_s2;
				end
			end
			default: nxt_st.rx_st = RX_IDLE;
		endcase

		// Sequencer.
		case (st_ff.st)
			ST_IDLE: begin
				if (st_ff.rx_st == RX_STOP && st_ff.rx_cnt == '0 &&
				    st_ff.rx_s2 && st_ff.rx_sh == `RSSR_CHAR_REQ) begin
					nxt_st.st      = ST_FETCH;
					nxt_st.total   = value_count(game_in, reel_count_in);
					nxt_st.ndig    = digit_count(game_in, max_value_in);
					nxt_st.cnt     = '0;
					nxt_st.rng_req = 1'b1;
					nxt_st.active  = 1'b1;
				end
			end
			ST_FETCH: begin
				// Values come unaltered from the play generator.
				if (st_ff.rng_req && rng_ack_in) begin
					nxt_st.vals[st_ff.cnt] = rng_value_in;
					nxt_st.cnt     = st_ff.cnt + 1'b1;
					nxt_st.rng_req = 1'b0;
					if (st_ff.cnt == st_ff.total - 1'b1) begin
						nxt_st.st   = ST_EMIT;
						nxt_st.idx  = '0;
						nxt_st.dpos = '0;
						nxt_st.sp   = 1'b0;
					end
				end else begin
					nxt_st.rng_req = 1'b1;
				end
			end
			ST_EMIT: begin
				if (!st_ff.push_vld || push_rdy) begin
					nxt_st.push_vld = 1'b1;
					if (st_ff.sp) begin
						nxt_st.push_data = `RSSR_CHAR_SPACE;
						nxt_st.sp   = 1'b0;
						nxt_st.idx  = st_ff.idx + 1'b1;
						nxt_st.dpos = '0;
					end else begin
						nxt_st.push_data = dec_char(st_ff.vals[st_ff.idx],
						    st_ff.ndig - st_ff.dpos - 2'h1);
						if (st_ff.dpos == st_ff.ndig - 2'h1) begin
							if (st_ff.idx == st_ff.total - 1'b1) begin
								nxt_st.st = ST_DRAIN;
							end else begin
								nxt_st.sp = 1'b1;
							end
						end else begin
							nxt_st.dpos = st_ff.dpos + 2'h1;
						end
					end
				end
			end
			ST_DRAIN: begin
				if (push_rdy) begin
					nxt_st.push_vld = 1'b0;
				end
				// Requests stay ignored until the last bit is on the line.
				if (!st_ff.push_vld && !pop_vld &&
				    st_ff.tx_st == TX_IDLE) begin
					nxt_st.st     = ST_IDLE;
					nxt_st.active = 1'b0;
				end
			end
			default: nxt_st.st = ST_IDLE;
		endcase

		// Transmitter, 8N1.
		if (st_ff.tx_cnt != '0) begin
			nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
		end
		case (st_ff.tx_st)
			TX_IDLE: begin
				nxt_st.tx = 1'b1;
				if (pop_vld) begin
					pop_rdy       = 1'b1;
					nxt_st.tx_st  = TX_SHIFT;
					nxt_st.tx_sh  = {1'b1, pop_data, 1'b0};
					nxt_st.tx_bit = '0;
					nxt_st.tx_cnt = `RSSR_CNT_W'(`RSSR_BIT_CYC - 1);
					nxt_st.tx     = 1'b0;
				end
			end
			TX_SHIFT: begin
				if (st_ff.tx_cnt == '0) begin
					nxt_st.tx_bit = st_ff.tx_bit + 1'b1;
					nxt_st.tx_sh  = {1'b1, st_ff.tx_sh[9:1]};
					nxt_st.tx_cnt = `RSSR_CNT_W'(`RSSR_BIT_CYC - 1);
					if (st_ff.tx_bit == `RSSR_FRAME_BITS - 4'h1) begin
						nxt_st.tx_st = TX_IDLE;
						nxt_st.tx    = 1'b1;
					end else begin
						nxt_st.tx = st_ff.tx_sh[1];
					end
				end
			end
			default: nxt_st.tx_st = TX_IDLE;
		endcase

		if (reset_in) begin
			nxt_st       = '0;
			nxt_st.rx_s1 = 1'b1;
			nxt_st.rx_s2 = 1'b1;
			nxt_st.tx    = 1'b1;
			pop_rdy      = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		st_ff <= nxt_st;
	end

	assign tx_out          = st_ff.tx;
	assign rng_req_out     = st_ff.rng_req;
	assign test_active_out = st_ff.active;
	assign frame_err_out   = st_ff.frame_err;
endmodule

/* tb/rssr_checker.sv */
`timescale 1ns/1ns
module rssr_checker (
	input  wire logic clk_in,          // Block clock.
	input  wire logic reset_in,        // Sync reset, high.
	input  wire logic rng_ack_in,      // Generator ack.
	input  wire logic tx_out,          // Serial send pin.
	input  wire logic rng_req_out,     // Value wanted.
	input  wire logic test_active_out, // Exchange running.
	input  wire logic frame_err_out    // Bad stop bit.
);
	`include "rssr_params.svh"
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Length of the current low run, so bit timing can be judged per run.
	logic [15:0] low_ff;
	always_ff @(posedge clk_in) begin
		low_ff <= tx_out ? 16'h0000 : low_ff + 16'h0001;
	end
	sequence s_grant;
		rng_req_out && rng_ack_in;
	endsequence
	sequence s_start;
		$rose(test_active_out);
	endsequence
	property p_reset;
		@(posedge clk_in) disable iff (1'b0) reset_in |=> tx_out &&
			!rng_req_out && !test_active_out && !frame_err_out;
	endproperty
	property p_req_in_test;
		rng_req_out |-> test_active_out;
	endproperty
	property p_req_hold;
		rng_req_out && !rng_ack_in |=> rng_req_out;
	endproperty
	property p_grant;
		s_grant |=> !rng_req_out;
	endproperty
	property p_start;
		s_start |-> $rose(rng_req_out);
	endproperty
	property p_quiet_fetch;
		rng_req_out |-> tx_out;
	endproperty
	property p_idle_line;
		!test_active_out |-> tx_out;
	endproperty
	property p_bit_len;
		$rose(tx_out) |-> low_ff != 16'h0000 &&
			(low_ff % `RSSR_BIT_CYC) == 0 && low_ff <= 9 * `RSSR_BIT_CYC;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not idle after reset");
	a_req_in_test: assert property (p_req_in_test)
		else $error("value wanted outside an exchange");
	a_req_hold: assert property (p_req_hold)
		else $error("value request dropped before ack");
	a_grant: assert property (p_grant)
		else $error("value request held after ack");
	a_start: assert property (p_start)
		else $error("exchange began without a value request");
	a_quiet_fetch: assert property (p_quiet_fetch)
		else $error("sending while values still fetched");
	a_idle_line: assert property (p_idle_line)
		else $error("send pin active outside an exchange");
	a_bit_len: assert property (p_bit_len)
		else $error("low run not a whole number of bit times");
endmodule
bind rssr_top rssr_checker u_chk (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.rng_ack_in(rng_ack_in),
	.tx_out(tx_out),
	.rng_req_out(rng_req_out),
	.test_active_out(test_active_out),
	.frame_err_out(frame_err_out)
);

/* tb/rssr_host_model.sv */
`timescale 1ns/1ns
module rssr_host_model (
	input  wire logic clk_in, // Block clock.
	input  wire logic tx_in,  // Device send pin.
	output logic      rx_out  // Device receive pin.
);
	`include "rssr_params.svh"
	logic [7:0] rxq[$];
	logic [7:0] b;
	initial rx_out = 1'b1;
	task automatic send_byte(input logic [7:0] v, input logic stop);
		@(negedge clk_in);
		rx_out = 1'b0;
		repeat (`RSSR_BIT_CYC) @(negedge clk_in);
		for (int i = 0; i < 8; i++) begin
			rx_out = v[i];
			repeat (`RSSR_BIT_CYC) @(negedge clk_in);
		end
		rx_out = stop;
		repeat (`RSSR_BIT_CYC) @(negedge clk_in);
		rx_out = 1'b1;
	endtask
	// Samples mid-bit; the stop bit is not judged, the byte count shows it.
	always begin
		@(negedge tx_in);
		repeat (`RSSR_HALF_CYC) @(negedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (`RSSR_BIT_CYC) @(negedge clk_in);
			b[i] = tx_in;
		end
		repeat (`RSSR_BIT_CYC) @(negedge clk_in);
		rxq.push_back(b);
	end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import rssr_pkg::*;
	`include "rssr_params.svh"
	typedef struct {
		rssr_game_t  g;
		logic [3:0]  rc;
		logic [7:0]  mx;
		logic [6:0]  n;
		logic [7:0]  v0;
		logic [7:0]  v1;
		string       s;
	} rssr_row_t;
	logic        clk_in;
	logic        reset_in;
	logic        rx_in;
	logic        rng_ack_in;
	logic        tx_out;
	logic        rng_req_out;
	logic        test_active_out;
	logic        frame_err_out;
	rssr_game_t  game_in;
	logic [3:0]  reel_count_in;
	logic [7:0]  max_value_in;
	logic [7:0]  rng_value_in;
	int          n_mismatch;
	int          num_checks;
	logic [7:0]  vq[$];
	rssr_row_t   rows[7];
	rssr_top dut (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.rx_in(rx_in),
		.game_in(game_in),
		.reel_count_in(reel_count_in),
		.max_value_in(max_value_in),
		.rng_value_in(rng_value_in),
		.rng_ack_in(rng_ack_in),
		.tx_out(tx_out),
		.rng_req_out(rng_req_out),
		.test_active_out(test_active_out),
		.frame_err_out(frame_err_out)
	);
	rssr_host_model host (
		.clk_in(clk_in),
		.tx_in(tx_out),
		.rx_out(rx_in)
	);
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Outside an ack the value bus toggles so a stale value is never reused.
	always @(negedge clk_in) begin
		if (rng_req_out === 1'b1 && rng_ack_in === 1'b0 && vq.size() > 0) begin
			rng_ack_in <= 1'b1;
			rng_value_in <= vq.pop_front();
		end else begin
			rng_ack_in <= 1'b0;
			rng_value_in <= ~rng_value_in;
		end
	end
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic run_one(input rssr_row_t r, input logic dup);
		int k;
		game_in = r.g;
		reel_count_in = r.rc;
		max_value_in = r.mx;
		host.rxq.delete();
		vq.delete();
		vq.push_back(r.v0);
		for (int j = 1; j < r.n; j++) begin
			vq.push_back(r.v1);
		end
		host.send_byte(8'h52, 1'b1);
		if (dup) begin
			host.send_byte(8'h52, 1'b1);
		end
		k = 0;
		while (test_active_out !== 1'b0 && k < 30000) begin
			@(negedge clk_in);
			k++;
		end
		chk("count", 8'(r.s.len()), 8'(host.rxq.size()));
		for (int i = 0; i < r.s.len(); i++) begin
			chk("char", r.s[i], host.rxq[i]);
		end
	endtask
	initial begin
		repeat (90000) @(posedge clk_in);
		n_mismatch++;
		final_report();
	end
	initial begin
		reset_in = 1'b1;
		game_in = GAME_ROUL;
		reel_count_in = 4'h0;
		max_value_in = 8'h00;
		rng_ack_in = 1'b0;
		rng_value_in = 8'h00;
		n_mismatch = 0;
		num_checks = 0;
		rows[0] = '{GAME_ROUL, 4'h0, 8'h24, 7'h01, 8'h07, 8'h00, "07"};
		rows[1] = '{GAME_ROUL, 4'h0, 8'hc8, 7'h01, 8'h05, 8'h00, "005"};
		rows[2] = '{GAME_SLOT, 4'h2, 8'h13, 7'h02, 8'h04, 8'h0c, "04 12"};
		rows[3] = '{GAME_CRAPS, 4'h0, 8'h06, 7'h02, 8'h06, 8'h01, "6 1"};
		rows[4] = '{GAME_POKER, 4'h0, 8'h33, 7'h0a, 8'h17, 8'h01, "23"};
		rows[5] = '{GAME_BJACK, 4'h0, 8'h33, 7'h12, 8'h33, 8'h00, "51"};
		rows[6] = '{GAME_KENO, 4'h0, 8'h50, 7'h14, 8'h50, 8'h09, "80"};
		// Ten poker cards, eighteen blackjack cards, twenty keno numbers.
		repeat (9) rows[4].s = {rows[4].s, " 01"};
		repeat (17) rows[5].s = {rows[5].s, " 00"};
		repeat (19) rows[6].s = {rows[6].s, " 09"};
		repeat (3) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk("idle", 8'h08, {4'h0, tx_out, rng_req_out, test_active_out,
			frame_err_out});
		foreach (rows[i]) begin
			run_one(rows[i], 1'b0);
		end
		host.send_byte(8'h51, 1'b1);
		repeat (`RSSR_BIT_CYC) @(negedge clk_in);
		chk("ignored", 8'h00, {7'h00, test_active_out});
		host.send_byte(8'h52, 1'b0);
		chk("bad_stop", 8'h02, {6'h00, frame_err_out, test_active_out});
		// A low stop bit can look like a new start; let that frame die out.
		repeat (12 * `RSSR_BIT_CYC) @(negedge clk_in);
		run_one(rows[3], 1'b1);
		repeat (2 * `RSSR_BIT_CYC) @(negedge clk_in);
		chk("rearmed", 8'h00, {6'h00, frame_err_out, test_active_out});
		final_report();
	end
endmodule
